/* design/flow_pkg.sv */
// Purpose: Shared constants for the program-flow and exception controller.
// Assumes: Byte-wide program memory with a 16-bit address space.
// Notes: Opcodes, vectors, flag positions and frame sizes live here only.
package flow_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 6;
  localparam int STEP_W = 3;
  localparam int REQ_LINES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Flag register bit positions: half carry, mask, sign, zero, overflow, carry.
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 4;
  localparam int FLAG_S = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  // The two unused top bits of the stacked or copied flag byte read as ones.
  localparam logic [1:0] FLAG_PAD = 2'h3;
  // Reset value: mask set, every other flag clear.
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Vector pairs, high byte at the lower address.
  localparam logic [ADDR_W-1:0] VEC_IRQ = 16'hfff8;
  localparam logic [ADDR_W-1:0] VEC_SWI = 16'hfffa;
  localparam logic [ADDR_W-1:0] VEC_NMI = 16'hfffc;
  localparam logic [ADDR_W-1:0] VEC_RESET = 16'hfffe;

  // Stack pointer value after reset; no opcode here loads it.
  localparam logic [ADDR_W-1:0] SP_RESET = 16'h01ff;

  ////////////////////////////////////////////////////////////////////////////
  // Frame lengths in bytes.
  localparam logic [STEP_W-1:0] FRAME_INT = 3'h7;
  localparam logic [STEP_W-1:0] FRAME_SUB = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes.
  localparam logic [7:0] OP_FLAG_LOAD = 8'h06;
  localparam logic [7:0] OP_FLAG_READ = 8'h07;
  localparam logic [7:0] OP_CLR_V = 8'h0a;
  localparam logic [7:0] OP_SET_V = 8'h0b;
  localparam logic [7:0] OP_CLR_C = 8'h0c;
  localparam logic [7:0] OP_SET_C = 8'h0d;
  localparam logic [7:0] OP_IMASK_CLR = 8'h0e;
  localparam logic [7:0] OP_IMASK_SET = 8'h0f;
  localparam logic [7:0] OP_JMP_REL = 8'h20;
  localparam logic [7:0] OP_BR_FIRST = 8'h22;
  localparam logic [7:0] OP_BR_LAST = 8'h2f;
  localparam logic [7:0] OP_RET_SUB = 8'h39;
  localparam logic [7:0] OP_RET_INT = 8'h3b;
  localparam logic [7:0] OP_WAIT = 8'h3e;
  localparam logic [7:0] OP_SWI = 8'h3f;
  localparam logic [7:0] OP_JMP_IDX = 8'h6e;
  localparam logic [7:0] OP_JMP_EXT = 8'h7e;
  localparam logic [7:0] OP_CALL_REL = 8'h8d;
  localparam logic [7:0] OP_CALL_IDX = 8'had;
  localparam logic [7:0] OP_CALL_EXT = 8'hbd;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, memory access phases and after-push actions.
  typedef enum logic [2:0] {
    S_RVEC, S_FETCH, S_OPND, S_EXEC, S_PUSH, S_PULL, S_VEC, S_WAIT
  } state_t;
  typedef enum logic [1:0] {PH_ISSUE, PH_HOLD, PH_DONE} phase_t;
  typedef enum logic [1:0] {POST_JUMP, POST_VEC, POST_WAIT} post_t;

endpackage

/* design/req_sync.sv */
// Purpose: Three-stage synchroniser and filter for the request pins.
// Assumes: Pins are asynchronous to CLOCK_I.
// Notes: A level counts once the second and third stages agree.
`timescale 1ns/1ps
module req_sync
  import flow_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pins, active low.
  input wire logic [REQ_LINES-1:0] pin_n_i,
  // Filtered requests, active high.
  output logic [REQ_LINES-1:0] req_o
);

  logic [REQ_LINES-1:0] stage1;
  logic [REQ_LINES-1:0] stage2;
  logic [REQ_LINES-1:0] stage3;

  ////////////////////////////////////////////////////////////////////////////
  // One chain per line; only stage2 reads stage1.
  for (genvar i = 0; i < REQ_LINES; i++) begin : g_line
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        stage1[i] <= 1'b1;
        stage2[i] <= 1'b1;
        stage3[i] <= 1'b1;
        req_o[i] <= 1'b0;
      end else begin
        stage1[i] <= pin_n_i[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
        if (stage2[i] == stage3[i]) begin
          req_o[i] <= ~stage3[i];
        end
      end
    end
  end

endmodule

/* design/branch_test.sv */
// Purpose: Evaluates the condition of a relative branch opcode.
// Assumes: Low nibble of opcodes 22 to 2F selects the test.
// Notes: Purely combinational.
`timescale 1ns/1ps
module branch_test
  import flow_pkg::*;
(
  // Opcode low nibble and current flags.
  input wire logic [3:0] cond_i,
  input wire logic [FLAG_W-1:0] flags_i,
  // Branch is taken.
  output logic take_o
);

  logic s;
  logic z;
  logic v;
  logic c;

  assign s = flags_i[FLAG_S];
  assign z = flags_i[FLAG_Z];
  assign v = flags_i[FLAG_V];
  assign c = flags_i[FLAG_C];

  ////////////////////////////////////////////////////////////////////////////
  // Condition table.
  always_comb begin
    case (cond_i)
      4'h2: take_o = ~c & ~z;
      4'h3: take_o = c | z;
      4'h4: take_o = ~c;
      4'h5: take_o = c;
      4'h6: take_o = ~z;
      4'h7: take_o = z;
      4'h8: take_o = ~v;
      4'h9: take_o = v;
      4'ha: take_o = ~s;
      4'hb: take_o = s;
      4'hc: take_o = ~(s ^ v);
      4'hd: take_o = s ^ v;
      4'he: take_o = ~z & ~(s ^ v);
      4'hf: take_o = z | (s ^ v);
      default: take_o = 1'b0;
    endcase
  end

endmodule

/* design/flow_control.sv */
// Purpose: Reset, interrupt, jump, branch and flag control of the CPU.
// Assumes: Memory answers a read in the cycle after the strobe.
// Notes: Opcodes outside this block execute as one-byte no-operations.
//
// Operation
// - Reset loads the program counter from FFFE (high) and FFFF (low).
// - Reset sets the interrupt mask.
// - Interrupt entry saves counter, index, both accumulators and flags.
// - Frame: counter low at start pointer, down to flags; pointer ends seven lower.
// - Mask is set after the frame is saved.
// - Vectors: FFF8 maskable, FFFA software, FFFC nonmaskable, high byte first.
// - Return from interrupt pulls flags, B, A, index, counter; pointer plus seven.
// - Restored flag byte brings back the mask state.
// - Two active-low level requests; nonmaskable high priority; held low.
// - Nonmaskable request is always honoured.
// - Maskable request honoured only while unmasked; 0E and 0F change mask.
// - 06 copies A into flags; 07 copies flags into A.
// - 0A/0B clear/set overflow; 0C/0D clear/set carry.
// - Jumps 20 relative, 6E indexed, 7E extended; stack and flags untouched.
// - Calls 8D, AD, BD push return address low at pointer; pointer minus two.
// - Return from subroutine 39 pulls counter; pointer plus two.
// - Software interrupt 3F stacks frame, sets mask, uses its vector.
// - Wait 3E stacks frame, then idles until an interrupt is accepted.
// - Branches 22 to 29 test carry, zero and overflow.
// - Branches 2A to 2F test sign, overflow and zero combinations.
// - Branch offset is signed, added to the address after the branch.
// - Sixteen-bit values: high byte at the address, low byte next.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module flow_control
  import flow_pkg::*;
(
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Backplane interrupt requests, active low.
  input wire logic NMI_REQ_N_I,
  input wire logic INT_REQ_N_I,
  // Program and stack memory.
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  output logic [DATA_W-1:0] MEM_WDATA_O,
  output logic MEM_RE_O,
  output logic MEM_WE_O,
  input wire logic [DATA_W-1:0] MEM_RDATA_I,
  // Processor state.
  output logic [ADDR_W-1:0] PC_O,
  output logic [ADDR_W-1:0] SP_O,
  output logic [ADDR_W-1:0] INDEX_O,
  output logic [DATA_W-1:0] ACC_A_O,
  output logic [DATA_W-1:0] ACC_B_O,
  output logic [FLAG_W-1:0] FLAGS_O,
  output logic WAITING_O
);

  state_t state;
  phase_t ph;
  post_t post;
  logic [STEP_W-1:0] step;
  logic [STEP_W-1:0] len;
  logic [1:0] opnd_cnt;
  logic [7:0] opcode;
  logic [7:0] op1;
  logic [7:0] op2;
  logic [ADDR_W-1:0] program_counter;
  logic [ADDR_W-1:0] stack_pointer;
  logic [ADDR_W-1:0] index_register;
  logic [DATA_W-1:0] acc_a;
  logic [DATA_W-1:0] acc_b;
  logic [FLAG_W-1:0] flags;
  logic [ADDR_W-1:0] vec_addr;
  logic [ADDR_W-1:0] target;
  logic [REQ_LINES-1:0] req;
  logic nmi_req;
  logic irq_req;
  logic take_int;
  logic wake;
  logic br_take;
  logic acc_active;
  logic acc_write;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [ADDR_W-1:0] rel_target;
  logic [ADDR_W-1:0] jmp_target;

  ////////////////////////////////////////////////////////////////////////////
  // Number of operand bytes that follow an opcode.
  function automatic logic [1:0] opnd_count(input logic [7:0] op);
    if (op == OP_JMP_EXT || op == OP_CALL_EXT) begin
      opnd_count = 2'h2;
    end else if (op == OP_JMP_REL || op == OP_JMP_IDX || op == OP_CALL_REL ||
                 op == OP_CALL_IDX || (op >= OP_BR_FIRST && op <= OP_BR_LAST)) begin
      opnd_count = 2'h1;
    end else begin
      opnd_count = 2'h0;
    end
  endfunction
  // Byte k of the push frame; index 0 sits at the starting pointer.
  function automatic logic [7:0] frame_byte(input logic [STEP_W-1:0] k,
      input logic [ADDR_W-1:0] pc, input logic [ADDR_W-1:0] ix, input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b, input logic [FLAG_W-1:0] f);
    case (k)
      3'h0: frame_byte = pc[7:0];
      3'h1: frame_byte = pc[15:8];
      3'h2: frame_byte = ix[7:0];
      3'h3: frame_byte = ix[15:8];
      3'h4: frame_byte = a;
      3'h5: frame_byte = b;
      default: frame_byte = {FLAG_PAD, f};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request pins pass a three-stage synchroniser.
  req_sync u_sync (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .pin_n_i({NMI_REQ_N_I, INT_REQ_N_I}),
    .req_o(req)
  );
  assign nmi_req = req[1];
  assign irq_req = req[0];
  // Branch condition from the opcode low nibble.
  branch_test u_branch (
    .cond_i(opcode[3:0]),
    .flags_i(flags),
    .take_o(br_take)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Interrupt acceptance: only at the opcode fetch or in the wait state, never mid-instruction.
  assign wake = nmi_req | (irq_req & ~flags[FLAG_I]);
  assign take_int = (state == S_FETCH) && (ph == PH_ISSUE) && wake;
  // Signed offset from the address after the two-byte branch.
  assign rel_target = program_counter + {{8{op1[7]}}, op1};
  // Jump and call targets by addressing mode.
  always_comb begin
    case (opcode)
      OP_JMP_REL, OP_CALL_REL: jmp_target = rel_target;
      OP_JMP_IDX, OP_CALL_IDX: jmp_target = index_register + {8'h00, op1};
      default: jmp_target = {op1, op2};
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Memory access that the current state asks for.
  always_comb begin
    acc_active = 1'b1;
    acc_write = 1'b0;
    acc_wdata = 8'h00;
    case (state)
      S_RVEC: acc_addr = VEC_RESET + {13'h0000, step};
      S_FETCH: begin
        acc_addr = program_counter;
        acc_active = ~take_int;
      end
      S_OPND: acc_addr = program_counter;
      S_PUSH: begin
        acc_addr = stack_pointer - {13'h0000, step};
        acc_write = 1'b1;
        acc_wdata = frame_byte(step, program_counter, index_register, acc_a, acc_b,
                               flags);
      end
      S_PULL: acc_addr = stack_pointer + {13'h0000, step} + 16'h0001;
      S_VEC: acc_addr = vec_addr + {13'h0000, step};
      default: begin
        acc_addr = program_counter;
        acc_active = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Memory port: strobe for one cycle, data taken two edges later.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MEM_ADDR_O <= 16'h0000;
      MEM_WDATA_O <= 8'h00;
      MEM_RE_O <= 1'b0;
      MEM_WE_O <= 1'b0;
    end else if (ph == PH_ISSUE && acc_active) begin
      MEM_ADDR_O <= acc_addr;
      MEM_WDATA_O <= acc_wdata;
      MEM_RE_O <= ~acc_write;
      MEM_WE_O <= acc_write;
    end else begin
      MEM_RE_O <= 1'b0;
      MEM_WE_O <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Instruction sequencer and processor registers.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= S_RVEC;
      ph <= PH_ISSUE;
      post <= POST_JUMP;
      step <= 3'h0;
      len <= 3'h0;
      opnd_cnt <= 2'h0;
      opcode <= 8'h00;
      op1 <= 8'h00;
      op2 <= 8'h00;
      program_counter <= 16'h0000;
      stack_pointer <= SP_RESET;
      index_register <= 16'h0000;
      acc_a <= 8'h00;
      acc_b <= 8'h00;
      flags <= FLAGS_RESET;
      vec_addr <= VEC_RESET;
      target <= 16'h0000;
    end else begin
      case (state)
        S_WAIT: begin
          // Frame is already stacked; accept and vector.
          if (wake) begin
            flags[FLAG_I] <= 1'b1;
            vec_addr <= nmi_req ? VEC_NMI : VEC_IRQ;
            step <= 3'h0;
            state <= S_VEC;
          end
        end
        S_EXEC: begin
          state <= S_FETCH;
          step <= 3'h0;
          case (opcode)
            OP_FLAG_LOAD: flags <= acc_a[FLAG_W-1:0];
            OP_FLAG_READ: acc_a <= {FLAG_PAD, flags};
            OP_CLR_V: flags[FLAG_V] <= 1'b0;
            OP_SET_V: flags[FLAG_V] <= 1'b1;
            OP_CLR_C: flags[FLAG_C] <= 1'b0;
            OP_SET_C: flags[FLAG_C] <= 1'b1;
            OP_IMASK_CLR: flags[FLAG_I] <= 1'b0;
            OP_IMASK_SET: flags[FLAG_I] <= 1'b1;
            OP_JMP_REL, OP_JMP_IDX, OP_JMP_EXT: program_counter <= jmp_target;
            OP_CALL_REL, OP_CALL_IDX, OP_CALL_EXT: begin
              target <= jmp_target;
              len <= FRAME_SUB;
              post <= POST_JUMP;
              state <= S_PUSH;
            end
            OP_RET_SUB: begin
              len <= FRAME_SUB;
              state <= S_PULL;
            end
            OP_RET_INT: begin
              len <= FRAME_INT;
              state <= S_PULL;
            end
            OP_SWI: begin
              len <= FRAME_INT;
              vec_addr <= VEC_SWI;
              post <= POST_VEC;
              state <= S_PUSH;
            end
            OP_WAIT: begin
              len <= FRAME_INT;
              post <= POST_WAIT;
              state <= S_PUSH;
            end
            default: begin
              // Conditional branches; anything else is a no-operation.
              if (opcode >= OP_BR_FIRST && opcode <= OP_BR_LAST && br_take) begin
                program_counter <= rel_target;
              end
            end
          endcase
        end
        default: begin
          case (ph)
            PH_ISSUE: begin
              if (take_int) begin
                vec_addr <= nmi_req ? VEC_NMI : VEC_IRQ;
                len <= FRAME_INT;
                post <= POST_VEC;
                step <= 3'h0;
                state <= S_PUSH;
              end else begin
                ph <= PH_HOLD;
              end
            end
            PH_HOLD: ph <= PH_DONE;
            default: begin
              ph <= PH_ISSUE;
              case (state)
                S_RVEC, S_VEC: begin
                  if (step == 3'h0) begin
                    program_counter[15:8] <= MEM_RDATA_I;
                    step <= 3'h1;
                  end else begin
                    program_counter[7:0] <= MEM_RDATA_I;
                    step <= 3'h0;
                    state <= S_FETCH;
                  end
                end
                S_FETCH: begin
                  opcode <= MEM_RDATA_I;
                  program_counter <= program_counter + 16'h0001;
                  opnd_cnt <= opnd_count(MEM_RDATA_I);
                  step <= 3'h0;
                  state <= (opnd_count(MEM_RDATA_I) == 2'h0) ? S_EXEC : S_OPND;
                end
                S_OPND: begin
                  if (step == 3'h0) begin
                    op1 <= MEM_RDATA_I;
                  end else begin
                    op2 <= MEM_RDATA_I;
                  end
                  program_counter <= program_counter + 16'h0001;
                  if (step[1:0] + 2'h1 == opnd_cnt) begin
                    step <= 3'h0;
                    state <= S_EXEC;
                  end else begin
                    step <= step + 3'h1;
                  end
                end
                S_PUSH: begin
                  if (step == len - 3'h1) begin
                    stack_pointer <= stack_pointer - {13'h0000, len};
                    step <= 3'h0;
                    case (post)
                      POST_JUMP: begin
                        program_counter <= target;
                        state <= S_FETCH;
                      end
                      POST_VEC: begin
                        flags[FLAG_I] <= 1'b1;
                        state <= S_VEC;
                      end
                      default: state <= S_WAIT;
                    endcase
                  end else begin
                    step <= step + 3'h1;
                  end
                end
                default: begin
                  // Pull: field index counts down from len minus one, the flag byte in an interrupt frame.
                  case (len - 3'h1 - step)
                    3'h6: flags <= MEM_RDATA_I[FLAG_W-1:0];
                    3'h5: acc_b <= MEM_RDATA_I;
                    3'h4: acc_a <= MEM_RDATA_I;
                    3'h3: index_register[15:8] <= MEM_RDATA_I;
                    3'h2: index_register[7:0] <= MEM_RDATA_I;
                    3'h1: program_counter[15:8] <= MEM_RDATA_I;
                    default: program_counter[7:0] <= MEM_RDATA_I;
                  endcase
                  if (step == len - 3'h1) begin
                    stack_pointer <= stack_pointer + {13'h0000, len};
                    step <= 3'h0;
                    state <= S_FETCH;
                  end else begin
                    step <= step + 3'h1;
                  end
                end
              endcase
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State outputs.
  assign PC_O = program_counter;
  assign SP_O = stack_pointer;
  assign INDEX_O = index_register;
  assign ACC_A_O = acc_a;
  assign ACC_B_O = acc_b;
  assign FLAGS_O = flags;
  assign WAITING_O = (state == S_WAIT);
endmodule

/* bench/flow_control_monitor.sv */
// Purpose: Port checker for the flow controller.
// Assumes: Memory strobes are registered one-cycle pulses.
// Notes: Bound to every flow_control instance.
`timescale 1ns/1ps
module flow_control_monitor
  import flow_pkg::*;
(
  // Clock, reset and request.
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic NMI_REQ_N_I,
  // Memory strobes and state.
  input wire logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_RE_O,
  input wire logic MEM_WE_O,
  input wire logic [ADDR_W-1:0] SP_O,
  input wire logic [FLAG_W-1:0] FLAGS_O,
  input wire logic WAITING_O
);
  // All checks share one clock and reset.
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // High while any byte access is issued.
  wire logic busy = MEM_RE_O | MEM_WE_O;
  ////////////////////////////////////////
  a_reset_vector: assert property ($fell(SYS_RST_I) |=>
    MEM_RE_O && MEM_ADDR_O == VEC_RESET ##3 MEM_RE_O && MEM_ADDR_O == 16'hffff)
    else $error("reset vector fetch wrong");
  a_reset_mask: assert property ($fell(SYS_RST_I) |-> FLAGS_O[FLAG_I])
    else $error("mask clear after reset");
  a_frame_window: assert property (MEM_WE_O |-> 16'(SP_O - MEM_ADDR_O) <= 16'h6)
    else $error("stack write outside frame");
  a_sp_steps: assert property (SP_O != $past(SP_O) |->
    16'(SP_O - $past(SP_O)) inside {16'h2, 16'h7, 16'hfffe, 16'hfff9})
    else $error("stack pointer step wrong");
  a_byte_spacing: assert property (busy |=> !busy [*2])
    else $error("byte accesses too close");
  a_vector_pair: assert property (MEM_RE_O && MEM_ADDR_O[15:3] == 13'h1fff &&
    !MEM_ADDR_O[0] |-> ##3 MEM_RE_O && MEM_ADDR_O == $past(MEM_ADDR_O, 3) + 16'h1)
    else $error("vector low byte not read next");
  a_wait_quiet: assert property (WAITING_O |-> !busy)
    else $error("memory access while waiting");
  a_nmi_in_wait: assert property ((WAITING_O && !NMI_REQ_N_I) [*2] |->
    ##[0:20] MEM_RE_O && MEM_ADDR_O == VEC_NMI)
    else $error("nonmaskable request not taken");
  // Main scenarios.
  c_nmi: cover property (MEM_RE_O && MEM_ADDR_O == VEC_NMI);
  c_irq: cover property (MEM_RE_O && MEM_ADDR_O == VEC_IRQ);
  c_wait: cover property ($rose(WAITING_O));
endmodule
bind flow_control flow_control_monitor mon_i (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
  .NMI_REQ_N_I(NMI_REQ_N_I), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RE_O(MEM_RE_O),
  .MEM_WE_O(MEM_WE_O), .SP_O(SP_O), .FLAGS_O(FLAGS_O), .WAITING_O(WAITING_O));

/* bench/mem_model.sv */
// Purpose: Program and stack memory beside the flow controller.
// Assumes: One answer in the cycle after each read strobe.
// Notes: Outside an answer the data lines invert every cycle.
`timescale 1ns/1ps
module mem_model
  import flow_pkg::*;
(
  // Clock, address and strobes.
  input wire logic clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic re_i,
  input wire logic we_i,
  // Read data.
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [0:65535];
  // Lines start at a known pattern.
  initial rdata_o = 8'ha5;
  // Answer for one cycle only, so a late capture sees a wrong value.
  always @(posedge clk_i) begin
    if (re_i) begin
      rdata_o <= mem[addr_i];
    end else begin
      rdata_o <= ~rdata_o;
    end
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule

/* bench/flow_control_tb.sv */
// Purpose: Self-checking bench for the flow controller.
// Assumes: The program image is loaded at time zero.
// Notes: Fetch addresses trace the program path.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module flow_control_tb
  import flow_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic nmi_n = 1'b1;
  logic int_n = 1'b1;
  logic re, we, waiting;
  logic [ADDR_W-1:0] addr, sp, pc, ix;
  logic [DATA_W-1:0] wdata, rdata, acc_a, acc_b;
  logic [FLAG_W-1:0] flags;
  int n_errors = 0;
  int samples_checked = 0;
  localparam logic [7:0] PROG [19] = '{8'h0e, 8'h0d, 8'h0b, 8'h28, 8'h10, 8'h2f, 8'h01,
    8'h01, 8'h7e, 8'h01, 8'h0c, 8'h01, 8'h8d, 8'h03, 8'h3f, 8'h3e, 8'h20, 8'hfe, 8'h39};
  localparam logic [7:0] VECS [8] = '{8'h02, 8'h00, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00};
  ////////////////////////////////////////
  // Design and memory.
  flow_control DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .NMI_REQ_N_I(nmi_n), .INT_REQ_N_I(int_n),
    .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_RE_O(re), .MEM_WE_O(we),
    .MEM_RDATA_I(rdata), .PC_O(pc), .SP_O(sp), .INDEX_O(ix), .ACC_A_O(acc_a), .ACC_B_O(acc_b),
    .FLAGS_O(flags), .WAITING_O(waiting));
  mem_model mem_i (.clk_i(clk), .addr_i(addr), .wdata_i(wdata), .re_i(re), .we_i(we),
    .rdata_o(rdata));
  // Clock of 8 ns period.
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Waits a bounded time for a read strobe at one address.
  task automatic seen(input logic [ADDR_W-1:0] a);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if (re === 1'b1 && addr === a) break;
    end
    `CHK(i < 400, 1'b1)
    if (i == 400) results();
  endtask
  // Reset leaves the mask set and starts at the reset vector.
  task automatic t_reset();
    seen(16'h0100);
    `CHK(pc, 16'h0100)
    `CHK(flags[FLAG_I], 1'b1)
    `CHK(sp, SP_RESET)
  endtask
  // Flag opcodes, branches, jump, call and return.
  task automatic t_flow();
    seen(16'h0105);
    `CHK(flags, 6'h03)
    seen(16'h0108);
    seen(16'h010c);
    seen(16'h0111);
    `CHK(sp, 16'h01fd)
    `CHK(mem_i.mem[16'h01ff], 8'h0e)
    `CHK(mem_i.mem[16'h01fe], 8'h01)
    seen(16'h010e);
    `CHK(sp, SP_RESET)
  endtask
  // Software interrupt frame, vector and return.
  task automatic t_swi();
    logic [7:0] fr [7] = '{8'h0f, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc3};
    seen(16'h0300);
    for (int k = 0; k < 7; k++) `CHK(mem_i.mem[16'h01ff - k], fr[k])
    `CHK(sp, 16'h01f8)
    `CHK(flags[FLAG_I], 1'b1)
    // Alter the stacked B and index bytes so that the pull is visible.
    mem_i.mem[16'h01fa] = 8'h5a;
    mem_i.mem[16'h01fc] = 8'h12;
    mem_i.mem[16'h01fd] = 8'h34;
    seen(16'h010f);
    `CHK(flags, 6'h03)
    `CHK(sp, SP_RESET)
    `CHK(acc_b, 8'h5a)
    `CHK(ix, 16'h1234)
  endtask
  // Wait stacks ahead, a nonmaskable request wakes it.
  task automatic t_wait();
    for (int i = 0; i < 100 && waiting !== 1'b1; i++) @(negedge clk);
    `CHK(waiting, 1'b1)
    if (waiting !== 1'b1) results();
    `CHK(mem_i.mem[16'h01ff], 8'h10)
    `CHK(mem_i.mem[16'h01f9], 8'hc3)
    @(posedge clk) nmi_n <= 1'b0;
    seen(VEC_NMI);
    @(posedge clk) nmi_n <= 1'b1;
    seen(16'h0403);
    `CHK(acc_a, 8'hd3)
    `CHK(flags, 6'h10)
    seen(16'h0404);
    `CHK(flags, 6'h13)
    seen(16'h0110);
    `CHK(flags, 6'h03)
    `CHK(acc_a, 8'h00)
  endtask
  // Maskable request taken, then ignored while masked; nonmaskable still wins.
  task automatic t_irq();
    int n;
    n = 0;
    @(posedge clk) int_n <= 1'b0;
    seen(VEC_IRQ);
    seen(16'h0200);
    for (int k = 0; k < 80; k++) begin
      @(negedge clk);
      if (re === 1'b1 && addr === VEC_IRQ) n++;
    end
    `CHK(n, 0)
    `CHK(sp, 16'h01f8)
    @(posedge clk) nmi_n <= 1'b0;
    seen(VEC_NMI);
    @(posedge clk) nmi_n <= 1'b1;
    seen(16'h0400);
    `CHK(sp, 16'h01f1)
    `CHK(mem_i.mem[16'h01f8], 8'h00)
    `CHK(mem_i.mem[16'h01f7], 8'h02)
  endtask
  ////////////////////////////////////////
  // Loads the image, resets, runs the scenarios.
  initial begin
    for (int i = 0; i < 19; i++) mem_i.mem[16'h0100 + i] = PROG[i];
    for (int i = 0; i < 8; i++) mem_i.mem[16'hfff8 + i] = VECS[i];
    mem_i.mem[16'h0200] = 8'h20;
    mem_i.mem[16'h0201] = 8'hfe;
    mem_i.mem[16'h0300] = 8'h3b;
    mem_i.mem[16'h0400] = 8'h07;
    mem_i.mem[16'h0401] = 8'h0a;
    mem_i.mem[16'h0402] = 8'h0c;
    mem_i.mem[16'h0403] = 8'h06;
    mem_i.mem[16'h0404] = 8'h3b;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flow();
    t_swi();
    t_wait();
    t_irq();
    results();
  end
endmodule
